// *** rtl/ncfg_top.sv ***
// nonvolatile clock ratio, options and configuration registers with key unlock
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ncfg_top (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               srst,
    // register port
    input  wire logic [3:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    // nonvolatile contents
    input  wire logic [7:0]         nonvolatile_options_byte,
    input  wire logic [63:0]        backdoor_compare_bytes,
    input  wire logic               blank_check_erased,
    // memory access from core and debug path
    input  wire ncfg_pkg::ncfg_acc_t acc_req,
    input  wire logic [7:0]         arr_rdata,
    output logic                    arr_wr,
    output logic      [7:0]         acc_rdata,
    // operation sequencing
    input  wire logic               op_req,
    input  wire logic [7:0]         op_pulses,
    output logic                    op_busy,
    output logic                    op_done,
    output logic                    op_refused,
    output logic                    nvm_tick,
    // option and config levels
    output logic                    vector_remap_off,
    output logic                    eeprom_sector_layout,
    output logic                    eeprom_page_choice,
    output logic                    device_secure
);
    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic                  ratio_loaded_flag_q;
    logic                  prescale_by_eight_q;
    logic [5:0]            clock_ratio_field_q;
    logic [7:0]            options_q;
    logic                  eeprom_page_choice_q;
    logic                  backdoor_entry_mode_q;
    logic                  key_matched_q;
    logic [7:0]            rdata_q;
    logic [2:0]            pre_cnt_q;
    logic [5:0]            div_cnt_q;
    logic                  tick_q;
    logic                  busy_q;
    logic [7:0]            pulses_q;
    logic                  done_q;
    logic                  refused_q;
    logic [3:0]            key_idx_q;
    logic                  key_bad_q;
    logic                  key_wr_last_q;
    logic [7:0]            key_buf_q [ncfg_pkg::KEY_BYTES];
    logic                  arr_wr_q;
    logic [7:0]            acc_rdata_q;
    logic                  secure_mirror_q;

    logic                  wr_ratio;
    logic                  wr_config;
    logic                  secure;
    logic                  key_addr_hit;
    logic                  key_capture;
    logic                  cmd_write;
    logic                  start_req;
    logic                  pre_tick;
    logic                  blocked;
    logic                  entry_clear;
    logic [7:0]            key_eq;
    logic [9:0]            period_cyc;
    logic                  rate_ok;

    assign wr_ratio     = reg_wr && (reg_addr == ncfg_pkg::OFS_CLOCK_RATIO);
    assign wr_config    = reg_wr && (reg_addr == ncfg_pkg::OFS_CONFIG);
    assign secure       = (options_q[1:0] != ncfg_pkg::LOCK_UNSECURED);
    assign key_addr_hit = acc_req.addr[15:3] == ncfg_pkg::KEY_BASE_ADDR[15:3];
    assign blocked      = secure && acc_req.secure_mem
                          && (!acc_req.trusted || acc_req.debug);
    // capture only from trusted firmware, never from the debug path
    assign key_capture  = acc_req.valid && acc_req.write && key_addr_hit
                          && backdoor_entry_mode_q && acc_req.trusted && !acc_req.debug
                          && options_q[ncfg_pkg::OPT_UNLOCK_BIT];
    assign cmd_write    = acc_req.valid && acc_req.write && key_addr_hit
                          && !backdoor_entry_mode_q && !blocked;
    assign start_req    = op_req || cmd_write;
    assign entry_clear  = wr_config && backdoor_entry_mode_q
                          && !reg_wdata[ncfg_pkg::CFG_ENTRY_BIT];
    assign pre_tick     = !prescale_by_eight_q
                          || (pre_cnt_q == ncfg_pkg::PRESCALE_LAST);
    assign period_cyc   = prescale_by_eight_q ? {7'(clock_ratio_field_q) + 7'h01, 3'h0}
                                              : {4'h0, clock_ratio_field_q} + 10'h001;
    // ratio cannot reach the window at fast bus rates; software reads this bit
    assign rate_ok      = (32'(period_cyc) >= ncfg_pkg::PULSE_MIN_CYC)
                          && (32'(period_cyc) <= ncfg_pkg::PULSE_MAX_CYC);

    // ----------------------------------------------------------------
    // clock ratio register, write once
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            ratio_loaded_flag_q <= 1'b0;
            prescale_by_eight_q <= 1'b0;
            clock_ratio_field_q <= 6'h00;
        end else if (wr_ratio && !ratio_loaded_flag_q) begin
            ratio_loaded_flag_q <= 1'b1;
            prescale_by_eight_q <= reg_wdata[ncfg_pkg::PRESCALE_BIT];
            clock_ratio_field_q <= reg_wdata[ncfg_pkg::RATIO_MSB:0];
        end
    end

    // ----------------------------------------------------------------
    // nvm clock enable divider
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst || !ratio_loaded_flag_q) begin
            pre_cnt_q <= 3'h0;
            div_cnt_q <= 6'h00;
            tick_q    <= 1'b0;
        end else begin
            pre_cnt_q <= pre_cnt_q + 3'h1;
            tick_q    <= 1'b0;
            if (pre_tick) begin
                if (div_cnt_q == 6'h00) begin
                    div_cnt_q <= clock_ratio_field_q;
                    tick_q    <= 1'b1;
                end else begin
                    div_cnt_q <= div_cnt_q - 6'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // operation sequencer, counts nvm ticks; the first tick after start may close a partial period
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            busy_q    <= 1'b0;
            pulses_q  <= 8'h00;
            done_q    <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            done_q    <= 1'b0;
            refused_q <= start_req && (!ratio_loaded_flag_q || busy_q);
            if (start_req && ratio_loaded_flag_q && !busy_q) begin
                busy_q   <= 1'b1;
                pulses_q <= (op_pulses == 8'h00) ? 8'h01 : op_pulses;
            end else if (busy_q && tick_q) begin
                pulses_q <= pulses_q - 8'h01;
                if (pulses_q == 8'h01) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // options register, loaded during reset
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            options_q <= nonvolatile_options_byte;
        end else if ((entry_clear && !key_bad_q && (key_idx_q == ncfg_pkg::KEY_DONE_IDX)
                      && (&key_eq)) || blank_check_erased) begin
            options_q[1:0] <= ncfg_pkg::LOCK_UNSECURED;
        end
    end

    // ----------------------------------------------------------------
    // config register and key capture
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            eeprom_page_choice_q  <= 1'b0;
            backdoor_entry_mode_q <= 1'b0;
            key_matched_q         <= 1'b0;
        end else begin
            if (wr_config) begin
                eeprom_page_choice_q  <= reg_wdata[ncfg_pkg::CFG_PAGE_BIT];
                backdoor_entry_mode_q <= reg_wdata[ncfg_pkg::CFG_ENTRY_BIT];
            end
            if (entry_clear && !key_bad_q && (key_idx_q == ncfg_pkg::KEY_DONE_IDX)
                && (&key_eq)) begin
                key_matched_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst || (wr_config && !backdoor_entry_mode_q)) begin
            key_idx_q     <= 4'h0;
            key_bad_q     <= 1'b0;
            key_wr_last_q <= 1'b0;
        end else begin
            key_wr_last_q <= key_capture;
            if (key_capture) begin
                // out of order, back to back or extra bytes spoil the entry
                if ((key_idx_q[2:0] != acc_req.addr[2:0]) || key_wr_last_q
                    || (key_idx_q == ncfg_pkg::KEY_DONE_IDX)) begin
                    key_bad_q <= 1'b1;
                end
                if (key_idx_q != ncfg_pkg::KEY_DONE_IDX) begin
                    key_idx_q <= key_idx_q + 4'h1;
                end
            end
        end
    end

    for (genvar g = 0; g < ncfg_pkg::KEY_BYTES; g++) begin : g_key
        always_ff @(posedge clock) begin
            if (srst) begin
                key_buf_q[g] <= ncfg_pkg::RESET_BYTE;
            end else if (key_capture && (key_idx_q == 4'(g))) begin
                key_buf_q[g] <= acc_req.wdata;
            end
        end
        assign key_eq[g] = key_buf_q[g] == backdoor_compare_bytes[8*g +: 8];
    end

    // ----------------------------------------------------------------
    // secure memory access gate
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            arr_wr_q    <= 1'b0;
            acc_rdata_q <= 8'h00;
        end else begin
            arr_wr_q <= acc_req.valid && acc_req.write && !blocked
                        && !(key_addr_hit && backdoor_entry_mode_q);
            if (acc_req.valid && !acc_req.write) begin
                acc_rdata_q <= blocked ? 8'h00 : arr_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // register read path
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst || !reg_rd) begin
            rdata_q <= 8'h00;
        end else if (reg_addr == ncfg_pkg::OFS_CLOCK_RATIO) begin
            rdata_q <= {ratio_loaded_flag_q, prescale_by_eight_q, clock_ratio_field_q};
        end else if (reg_addr == ncfg_pkg::OFS_OPTIONS) begin
            rdata_q <= {options_q[7:5], 3'h0, options_q[1:0]};
        end else if (reg_addr == ncfg_pkg::OFS_CONFIG) begin
            rdata_q <= {1'b0, eeprom_page_choice_q, backdoor_entry_mode_q, 5'h00};
        end else if (reg_addr == ncfg_pkg::OFS_STATUS) begin
            rdata_q <= {3'h0, key_matched_q, rate_ok, busy_q, secure, ratio_loaded_flag_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata            = rdata_q;
    assign arr_wr               = arr_wr_q;
    assign acc_rdata            = acc_rdata_q;
    assign op_busy              = busy_q;
    assign op_done              = done_q;
    assign op_refused           = refused_q;
    assign nvm_tick             = tick_q;
    assign vector_remap_off     = options_q[ncfg_pkg::OPT_REMAP_OFF_BIT];
    assign eeprom_sector_layout = options_q[ncfg_pkg::OPT_LAYOUT_BIT];
    assign eeprom_page_choice   = eeprom_page_choice_q;
    assign device_secure        = secure_mirror_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            secure_mirror_q <= 1'b1;
        end else begin
            secure_mirror_q <= secure;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_idle7;
        !tick_q [*7];
    endsequence

    a_ratio_write_once: assert property (@(posedge clock) disable iff (srst)
        ratio_loaded_flag_q && wr_ratio |=> $stable({prescale_by_eight_q, clock_ratio_field_q}))
        else $error("ratio changed after first write");
    a_loaded_first_write: assert property (@(posedge clock) disable iff (srst)
        wr_ratio |=> ratio_loaded_flag_q)
        else $error("loaded flag not set by write");
    a_refuse_unloaded: assert property (@(posedge clock) disable iff (srst)
        op_req && !ratio_loaded_flag_q |=> refused_q && !busy_q)
        else $error("operation taken before ratio loaded");
    a_tick_ratio_one: assert property (@(posedge clock) disable iff (srst)
        tick_q && !prescale_by_eight_q && clock_ratio_field_q == 6'h01 |=> !tick_q ##1 tick_q)
        else $error("divide by two spacing wrong");
    a_tick_prescale: assert property (@(posedge clock) disable iff (srst)
        tick_q && prescale_by_eight_q && clock_ratio_field_q == 6'h00 |=> s_idle7 ##1 tick_q)
        else $error("prescale spacing wrong");
    a_options_reset: assert property (@(posedge clock) disable iff (srst)
        $past(srst) |-> options_q == $past(nonvolatile_options_byte))
        else $error("options not loaded at reset");
    a_debug_no_key: assert property (@(posedge clock) disable iff (srst)
        acc_req.valid && acc_req.write && acc_req.debug && key_addr_hit && !wr_config
        |=> $stable(key_idx_q))
        else $error("debug write captured key byte");
    a_blocked_read_zero: assert property (@(posedge clock) disable iff (srst)
        acc_req.valid && !acc_req.write && blocked |=> acc_rdata_q == 8'h00 && !arr_wr_q)
        else $error("blocked read returned data");
    a_blank_unsecures: assert property (@(posedge clock) disable iff (srst)
        blank_check_erased |=> !secure ##1 !device_secure)
        else $error("blank check did not unsecure");
endmodule // ncfg_top
`default_nettype wire

// *** shared/ncfg_pkg.sv ***
// constants and carrier types for the nonvolatile clock, option and config registers
package ncfg_pkg;
    // ----------------------------------------------------------------
    // register map on the plain register port
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_CLOCK_RATIO = 4'h0;
    localparam logic [3:0] OFS_OPTIONS     = 4'h1;
    localparam logic [3:0] OFS_CONFIG      = 4'h2;
    localparam logic [3:0] OFS_STATUS      = 4'h3;

    // ----------------------------------------------------------------
    // field positions and values
    // ----------------------------------------------------------------
    localparam int          RATIO_LOADED_BIT   = 7;
    localparam int          PRESCALE_BIT       = 6;
    localparam int          RATIO_MSB          = 5;
    localparam int          OPT_UNLOCK_BIT     = 7;
    localparam int          OPT_REMAP_OFF_BIT  = 6;
    localparam int          OPT_LAYOUT_BIT     = 5;
    localparam logic [1:0]  LOCK_UNSECURED     = 2'h2;
    localparam int          CFG_PAGE_BIT       = 6;
    localparam int          CFG_ENTRY_BIT      = 5;
    localparam logic [2:0]  PRESCALE_LAST      = 3'h7;
    localparam logic [15:0] KEY_BASE_ADDR      = 16'hffb0;
    localparam int          KEY_BYTES          = 8;
    localparam logic [3:0]  KEY_DONE_IDX       = 4'h8;
    localparam logic [7:0]  RESET_BYTE         = 8'h00;

    // ----------------------------------------------------------------
    // timing pulse window
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 8000;
    localparam int PULSE_MIN_NS   = 5000;
    localparam int PULSE_MAX_NS   = 6700;
    localparam int PULSE_MIN_CYC  = (PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_MAX_CYC  = (PULSE_MAX_NS * 1000) / CLK_PERIOD_PS;

    // memory access from the core or the debug path, one cycle per request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        trusted;
        logic        debug;
        logic        secure_mem;
    } ncfg_acc_t;
endpackage

// *** sim/ncfg_top_test.sv ***
// self-checking bench for the nonvolatile clock, option and config registers
`timescale 1ns/1ps
`default_nettype none
module ncfg_top_test;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic                clock;
    logic                srst;
    logic [3:0]          reg_addr;
    logic [7:0]          reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [7:0]          reg_rdata;
    logic [7:0]          nonvolatile_options_byte;
    logic [63:0]         backdoor_compare_bytes;
    logic                blank_check_erased;
    ncfg_pkg::ncfg_acc_t acc_req;
    logic [7:0]          arr_rdata;
    logic                arr_wr;
    logic [7:0]          acc_rdata;
    logic                op_req;
    logic [7:0]          op_pulses;
    logic                op_busy;
    logic                op_done;
    logic                op_refused;
    logic                nvm_tick;
    logic                vector_remap_off;
    logic                eeprom_sector_layout;
    logic                eeprom_page_choice;
    logic                device_secure;
    int                  n_errors;
    int                  tests_run;
    logic [7:0]          rd_v;
    int                  n;

    ncfg_top i_dut (
        .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nonvolatile_options_byte(nonvolatile_options_byte),
        .backdoor_compare_bytes(backdoor_compare_bytes),
        .blank_check_erased(blank_check_erased), .acc_req(acc_req), .arr_rdata(arr_rdata),
        .arr_wr(arr_wr), .acc_rdata(acc_rdata), .op_req(op_req), .op_pulses(op_pulses),
        .op_busy(op_busy), .op_done(op_done), .op_refused(op_refused), .nvm_tick(nvm_tick),
        .vector_remap_off(vector_remap_off), .eeprom_sector_layout(eeprom_sector_layout),
        .eeprom_page_choice(eeprom_page_choice), .device_secure(device_secure)
    );

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h0, got}, {7'h0, exp});
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask

    task automatic do_reset(input logic [7:0] opt);
        @(posedge clock);
        nonvolatile_options_byte <= opt;
        srst <= 1'b1;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        idle(1);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // one access; results are sampled in the cycle after it is taken
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                       input logic tr, input logic dbg);
        ncfg_pkg::ncfg_acc_t t;
        t = '{valid: 1'b1, write: w, addr: a, wdata: d, trusted: tr, debug: dbg,
              secure_mem: 1'b1};
        @(posedge clock);
        acc_req <= t;
        @(posedge clock);
        acc_req <= '0;
        #1;
    endtask

    // cycles between two divider enables
    task automatic tick_period(output int p);
        int k;
        k = 0;
        while (nvm_tick !== 1'b1 && k < 2000) begin
            idle(1);
            k++;
        end
        p = 0;
        do begin
            idle(1);
            p++;
        end while (nvm_tick !== 1'b1 && p < 2000);
    endtask

    // entry mode on, eight key bytes with a gap, entry mode off
    task automatic key_seq(input logic spoil);
        wr_reg(ncfg_pkg::OFS_CONFIG, 8'h20);
        for (int i = 0; i < ncfg_pkg::KEY_BYTES; i++) begin
            acc(1'b1, ncfg_pkg::KEY_BASE_ADDR + 16'(i), 8'((i + 1) * 17), 1'b1, spoil && i == 0);
            idle(1);
        end
        wr_reg(ncfg_pkg::OFS_CONFIG, 8'h00);
        idle(3);
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        #300us;
        n_errors++;
        wrap_up();
    end

    initial begin
        n_errors = 0;
        tests_run = 0;
        srst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        nonvolatile_options_byte = 8'h21;
        backdoor_compare_bytes = 64'h8877665544332211;
        blank_check_erased = 1'b0;
        acc_req = '0;
        arr_rdata = 8'h5a;
        op_req = 1'b0;
        op_pulses = 8'h02;
        do_reset(8'h21);
        rd_reg(ncfg_pkg::OFS_OPTIONS, rd_v);
        chk8(rd_v, 8'h21);
        chk1(eeprom_sector_layout, 1'b1);
        chk1(vector_remap_off, 1'b0);
        rd_reg(ncfg_pkg::OFS_CLOCK_RATIO, rd_v);
        chk8(rd_v, 8'h00);
        @(posedge clock);
        op_req <= 1'b1;
        @(posedge clock);
        op_req <= 1'b0;
        #1 chk1(op_refused, 1'b1);
        acc(1'b0, 16'h1800, 8'h00, 1'b0, 1'b0);
        chk8(acc_rdata, 8'h00);
        acc(1'b1, 16'h1800, 8'h33, 1'b1, 1'b1);
        chk1(arr_wr, 1'b0);
        acc(1'b0, 16'h1800, 8'h00, 1'b1, 1'b0);
        chk8(acc_rdata, 8'h5a);
        acc(1'b1, 16'h1800, 8'h33, 1'b1, 1'b0);
        chk1(arr_wr, 1'b1);
        wr_reg(ncfg_pkg::OFS_CLOCK_RATIO, 8'h41);
        rd_reg(ncfg_pkg::OFS_CLOCK_RATIO, rd_v);
        chk8(rd_v, 8'hc1);
        rd_reg(ncfg_pkg::OFS_STATUS, rd_v);
        chk8(rd_v, 8'h03);
        wr_reg(ncfg_pkg::OFS_CLOCK_RATIO, 8'h05);
        rd_reg(ncfg_pkg::OFS_CLOCK_RATIO, rd_v);
        chk8(rd_v, 8'hc1);
        tick_period(n);
        chk8(8'(n), 8'h10);
        @(posedge clock);
        op_req <= 1'b1;
        @(posedge clock);
        op_req <= 1'b0;
        n = 0;
        #1 chk1(op_refused, 1'b0);
        while (op_done !== 1'b1 && n < 200) begin
            idle(1);
            n++;
        end
        chk1(n >= 15 && n <= 33, 1'b1);
        key_seq(1'b0);
        chk1(device_secure, 1'b1);
        wr_reg(ncfg_pkg::OFS_CONFIG, 8'h40);
        rd_reg(ncfg_pkg::OFS_CONFIG, rd_v);
        chk8(rd_v, 8'h40);
        chk1(eeprom_page_choice, 1'b1);
        do_reset(8'hc0);
        chk1(vector_remap_off, 1'b1);
        wr_reg(ncfg_pkg::OFS_CLOCK_RATIO, 8'h04);
        tick_period(n);
        chk8(8'(n), 8'h05);
        key_seq(1'b1);
        chk1(device_secure, 1'b1);
        key_seq(1'b0);
        chk1(device_secure, 1'b0);
        rd_reg(ncfg_pkg::OFS_OPTIONS, rd_v);
        chk8(rd_v, 8'hc2);
        rd_reg(ncfg_pkg::OFS_STATUS, rd_v);
        chk8(rd_v, 8'h11);
        acc(1'b1, ncfg_pkg::KEY_BASE_ADDR, 8'h00, 1'b1, 1'b0);
        chk1(op_busy, 1'b1);
        idle(20);
        // only one of the four lock codes leaves the device open
        for (int c = 0; c < 4; c++) begin
            do_reset({6'h00, 2'(c)});
            idle(2);
            chk1(device_secure, 1'(c != 2));
        end
        wr_reg(ncfg_pkg::OFS_CLOCK_RATIO, 8'h40);
        tick_period(n);
        chk8(8'(n), 8'h08);
        @(posedge clock);
        blank_check_erased <= 1'b1;
        @(posedge clock);
        blank_check_erased <= 1'b0;
        idle(3);
        chk1(device_secure, 1'b0);
        do_reset(8'h02);
        wr_reg(ncfg_pkg::OFS_CLOCK_RATIO, 8'h01);
        tick_period(n);
        chk8(8'(n), 8'h02);
        wrap_up();
    end
endmodule // ncfg_top_test
`default_nettype wire
